// ===== hw/wit_params.svh
// Offsets, field positions, reset values and counts of the supervisory timer
`ifndef WIT_PARAMS_SVH
`define WIT_PARAMS_SVH

// ===================================================================
// Register indices (byte address is four times the index)
`define WIT_IDX_CTL_WR   20'hfff8c
`define WIT_IDX_CTL_RD   20'hfff8c
`define WIT_IDX_CNT_RD   20'hfff8d
`define WIT_IDX_RST_WR   20'hfff8e
`define WIT_IDX_RST_RD   20'hfff8f

// ===================================================================
// Passwords in the upper byte of a word write, flag clear value in the lower byte
`define WIT_PW_CNT       8'h5a
`define WIT_PW_CTL       8'ha5
`define WIT_RST_CLR_VAL  8'h00

// ===================================================================
// Field positions
`define WIT_OVF_BIT      7
`define WIT_MODE_BIT     6
`define WIT_TME_BIT      5
`define WIT_WATCHDOG_RESET_FLAG_BIT     7
`define WIT_RESET_OUTPUT_ENABLE_BIT    6

// ===================================================================
// Reset values, fixed read bits and counter top value
`define WIT_CTL_RESET    8'h18
`define WIT_CNT_RESET    8'h00
`define WIT_RST_RESET    8'h3f
`define WIT_CTL_RSVD     2'h3
`define WIT_RST_RSVD     6'h3f
`define WIT_CNT_MAX      8'hff

// ===================================================================
// Counts in states of the system clock, prescaler width in bits
`define WIT_INT_RST_STATES 10'd518
`define WIT_EXT_RST_STATES 10'd132
`define WIT_PRE_WIDTH      12
// Prescaler shifts per clock select code, code 7 in top nibble
`define WIT_TAP_SHIFTS     32'hcb98_7651

`endif

// ===== hw/wit_pkg.sv
// Types shared by the supervisory timer files
package wit_pkg;

   // ===================================================================
   // Reset sequencer states
   typedef enum logic [1:0] {
      WIT_S_IDLE = 2'b01,
      WIT_S_RST  = 2'b10
   } wit_seq_type;

   typedef logic [2:0] wit_cks_type;
   typedef logic [7:0] wit_byte_type;

endpackage : wit_pkg

// ===== hw/wit_prescaler.sv
// Free-running prescaler giving one-cycle count pulses per selected tap
`include "wit_params.svh"

module wit_prescaler
   import wit_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire wit_cks_type clock_select,
   output logic             count_pulse
);

   localparam logic [31:0] TAPS = `WIT_TAP_SHIFTS;

   logic [`WIT_PRE_WIDTH-1:0] pre_r;
   logic [7:0]                tap;

   // ===================================================================
   // Prescaler
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + 1'b1;
      end
   end

   // ===================================================================
   // Tap decode
   for (genvar i = 0; i < 8; i++) begin : g_tap
      localparam logic [3:0] SH = TAPS[4*i +: 4];
      localparam logic [`WIT_PRE_WIDTH-1:0] MASK = ~({`WIT_PRE_WIDTH{1'b1}} << SH);
      assign tap[i] = ((pre_r & MASK) == MASK);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_pulse <= 1'b0;
      end else begin
         count_pulse <= tap[clock_select];
      end
   end

endmodule : wit_prescaler

// ===== hw/wit_top.sv
// Supervisory timer: counter, modes, reset generation and Avalon-MM registers
`include "wit_params.svh"

module wit_top
   import wit_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   input  wire logic [19:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        standby,
   output logic             interval_interrupt,
   output logic             chip_reset_n,
   output logic             external_reset_output_o,
   output logic             external_reset_output_oe
);

   logic         ack_r;
   logic [31:0]  rdata_r;
   logic         wr_go;
   logic         rd_go;
   logic         word_wr;
   wit_byte_type wr_lo;
   wit_byte_type wr_hi;
   logic         cnt_wr;
   logic         ctl_wr;
   logic         rst_wr;
   logic         ovf_r;
   logic         mode_r;
   logic         tme_r;
   wit_cks_type  cks_r;
   wit_byte_type count_value_r;
   wit_byte_type count_value_nxt;
   logic         watchdog_reset_flag_r;
   logic         reset_output_enable_r;
   logic         ovf_seen_r;
   logic         watchdog_reset_flag_seen_r;
   logic         count_pulse;
   logic         inc;
   logic         wrap;
   logic         wd_fire;
   logic         chip_clr;
   wit_seq_type  seq_r;
   logic [9:0]   int_cnt_r;
   logic [9:0]   ext_cnt_r;
   wit_byte_type ctl_val;
   wit_byte_type rst_val;
   localparam wit_byte_type CTL_RST = `WIT_CTL_RESET;
   localparam wit_byte_type RST_RST = `WIT_RST_RESET;

   // ===================================================================
   // Avalon-MM slave: one wait cycle, then answer
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign wr_go   = avs_write & ack_r;
   assign rd_go   = avs_read & ack_r;
   assign word_wr = (avs_byteenable[1:0] == 2'b11);
   assign wr_lo   = avs_writedata[7:0];
   assign wr_hi   = avs_writedata[15:8];
   assign cnt_wr  = wr_go & word_wr & (avs_address == `WIT_IDX_CTL_WR)
                    & (wr_hi == `WIT_PW_CNT) & ~chip_clr;
   assign ctl_wr  = wr_go & word_wr & (avs_address == `WIT_IDX_CTL_WR)
                    & (wr_hi == `WIT_PW_CTL) & ~chip_clr;
   assign rst_wr  = wr_go & word_wr & (avs_address == `WIT_IDX_RST_WR);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end

   // ===================================================================
   // Read data
   assign ctl_val = {ovf_r, mode_r, tme_r, `WIT_CTL_RSVD, cks_r};
   assign rst_val = {watchdog_reset_flag_r, reset_output_enable_r, `WIT_RST_RSVD};

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         case (avs_address)
            `WIT_IDX_CTL_RD: rdata_r <= {24'h00_0000, ctl_val};
            `WIT_IDX_CNT_RD: rdata_r <= {24'h00_0000, count_value_r};
            `WIT_IDX_RST_RD: rdata_r <= {24'h00_0000, rst_val};
            default:         rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ===================================================================
   // Prescaler
   wit_prescaler u_pre (
      .ref_clk      (ref_clk),
      .arst_n       (arst_n),
      .clock_select (cks_r),
      .count_pulse  (count_pulse)
   );

   // ===================================================================
   // Counter
   assign inc     = tme_r & count_pulse & ~cnt_wr & ~chip_clr;
   assign wrap    = inc & (count_value_r == `WIT_CNT_MAX);
   assign wd_fire = wrap & mode_r & (seq_r == WIT_S_IDLE);

   always_comb begin
      count_value_nxt = count_value_r;
      if (!tme_r || chip_clr) begin
         count_value_nxt = `WIT_CNT_RESET;
      end else if (cnt_wr) begin
         count_value_nxt = wr_lo;
      end else if (inc) begin
         count_value_nxt = count_value_r + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_value_r <= `WIT_CNT_RESET;
      end else begin
         count_value_r <= count_value_nxt;
      end
   end

   // ===================================================================
   // Control register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= CTL_RST[`WIT_MODE_BIT];
         tme_r  <= CTL_RST[`WIT_TME_BIT];
         cks_r  <= CTL_RST[2:0];
      end else if (chip_clr) begin
         mode_r <= 1'b0;
         tme_r  <= 1'b0;
         cks_r  <= 3'h0;
      end else if (standby) begin
         mode_r <= 1'b0;
         tme_r  <= 1'b0;
      end else if (ctl_wr) begin
         mode_r <= wr_lo[`WIT_MODE_BIT];
         tme_r  <= wr_lo[`WIT_TME_BIT];
         cks_r  <= wr_lo[2:0];
      end
   end

   // ===================================================================
   // Overflow flag, set wins over write clear, standby clear wins over set
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_r      <= 1'b0;
         ovf_seen_r <= 1'b0;
      end else if (chip_clr || standby) begin
         ovf_r      <= 1'b0;
         ovf_seen_r <= 1'b0;
      end else begin
         if (wrap) begin
            ovf_r <= 1'b1;
         end else if (ctl_wr && !wr_lo[`WIT_OVF_BIT] && ovf_seen_r) begin
            ovf_r <= 1'b0;
         end
         if (ctl_wr) begin
            ovf_seen_r <= 1'b0;
         end else if (rd_go && avs_address == `WIT_IDX_CTL_RD && rdata_r[`WIT_OVF_BIT]) begin
            ovf_seen_r <= 1'b1;
         end
      end
   end

   assign interval_interrupt = ovf_r & ~mode_r;

   // ===================================================================
   // Reset control register, kept through watchdog reset; flag cleared by pin reset or by password write after read
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_reset_flag_r      <= RST_RST[`WIT_WATCHDOG_RESET_FLAG_BIT];
         reset_output_enable_r     <= RST_RST[`WIT_RESET_OUTPUT_ENABLE_BIT];
         watchdog_reset_flag_seen_r <= 1'b0;
      end else begin
         if (wd_fire) begin
            watchdog_reset_flag_r <= 1'b1;
         end else if (rst_wr && wr_hi == `WIT_PW_CTL && wr_lo == `WIT_RST_CLR_VAL && watchdog_reset_flag_seen_r) begin
            watchdog_reset_flag_r <= 1'b0;
         end
         if (rst_wr && wr_hi == `WIT_PW_CNT) begin
            reset_output_enable_r <= wr_lo[`WIT_RESET_OUTPUT_ENABLE_BIT];
         end
         if (rst_wr) begin
            watchdog_reset_flag_seen_r <= 1'b0;
         end else if (rd_go && avs_address == `WIT_IDX_RST_RD && rdata_r[`WIT_WATCHDOG_RESET_FLAG_BIT]) begin
            watchdog_reset_flag_seen_r <= 1'b1;
         end
      end
   end

   // ===================================================================
   // Watchdog reset sequencer
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_r     <= WIT_S_IDLE;
         int_cnt_r <= 10'd0;
      end else begin
         case (seq_r)
            WIT_S_IDLE: begin
               if (wd_fire) begin
                  seq_r     <= WIT_S_RST;
                  int_cnt_r <= `WIT_INT_RST_STATES - 10'd1;
               end
            end
            WIT_S_RST: begin
               if (int_cnt_r == 10'd0) begin
                  seq_r <= WIT_S_IDLE;
               end else begin
                  int_cnt_r <= int_cnt_r - 10'd1;
               end
            end
            default: begin
               seq_r     <= WIT_S_IDLE;
               int_cnt_r <= 10'd0;
            end
         endcase
      end
   end

   assign chip_clr     = (seq_r == WIT_S_RST);
   assign chip_reset_n = ~chip_clr;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_cnt_r <= 10'd0;
      end else if (wd_fire && reset_output_enable_r) begin
         ext_cnt_r <= `WIT_EXT_RST_STATES;
      end else if (ext_cnt_r != 10'd0) begin
         ext_cnt_r <= ext_cnt_r - 10'd1;
      end
   end

   assign external_reset_output_o  = 1'b0;
   assign external_reset_output_oe = (ext_cnt_r != 10'd0);

   // ===================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   logic [9:0] int_len_h;
   logic [9:0] ext_len_h;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         int_len_h <= 10'd0;
         ext_len_h <= 10'd0;
      end else begin
         int_len_h <= chip_clr ? int_len_h + 10'd1 : 10'd0;
         ext_len_h <= external_reset_output_oe ? ext_len_h + 10'd1 : 10'd0;
      end
   end

   chk_cnt_hold: assert property (!tme_r |=> count_value_r == 8'h00)
      else $error("counter not held at zero");
   chk_cnt_inc: assert property (inc && !wrap |=> count_value_r == $past(count_value_r) + 8'h01)
      else $error("counter did not increment");
   chk_ovf_set: assert property (wrap && !standby |=> ovf_r)
      else $error("overflow flag not set on wrap");
   chk_irq_mode: assert property (wrap && !mode_r && !standby && !ctl_wr |=> interval_interrupt)
      else $error("interval interrupt missing");
   chk_watchdog_reset_flag_set: assert property (wd_fire |=> watchdog_reset_flag_r && chip_clr)
      else $error("watchdog reset flag not set");
   chk_int_len: assert property ($fell(chip_clr) |-> int_len_h == 10'd518)
      else $error("internal reset length wrong");
   chk_ext_len: assert property ($fell(external_reset_output_oe) |-> ext_len_h == 10'd132)
      else $error("external reset length wrong");
   chk_pin_enable: assert property (wd_fire && !reset_output_enable_r |=> !external_reset_output_oe[*3])
      else $error("external reset driven while disabled");
   chk_wr_prio: assert property (cnt_wr && tme_r |=> count_value_r == $past(wr_lo))
      else $error("counter write lost");
   chk_rsvd_read: assert property (rd_go && avs_address == `WIT_IDX_CTL_RD |-> avs_readdata[4:3] == 2'b11)
      else $error("reserved bits not one");
   chk_watchdog_reset_flag_keep: assert property (chip_clr && watchdog_reset_flag_r |=> watchdog_reset_flag_r)
      else $error("watchdog reset flag lost");

   // ===================================================================
   // Register and bus guards
   chk_ack_single: assert property (ack_r |=> !ack_r)
      else $error("bus answer longer than one cycle");
   chk_byte_ignore: assert property (wr_go && !word_wr && !chip_clr |=> $stable(cks_r) && $stable(reset_output_enable_r))
      else $error("byte write changed a register");
   chk_reset_output_enable_load: assert property (rst_wr && wr_hi == `WIT_PW_CNT |=> reset_output_enable_r == $past(wr_lo[`WIT_RESET_OUTPUT_ENABLE_BIT]))
      else $error("reset output enable not loaded");
   chk_cks_load: assert property (ctl_wr && !standby |=> cks_r == $past(wr_lo[2:0]))
      else $error("clock select not loaded");
   chk_mode_load: assert property (ctl_wr && !standby |=> mode_r == $past(wr_lo[`WIT_MODE_BIT]))
      else $error("mode select not loaded");
   chk_tme_load: assert property (ctl_wr && !standby |=> tme_r == $past(wr_lo[`WIT_TME_BIT]))
      else $error("count enable not loaded");
   chk_standby_clr: assert property (standby && !chip_clr |=> !tme_r && !mode_r && !ovf_r && $stable(cks_r))
      else $error("standby clear wrong");
   chk_ovf_guard: assert property (ovf_r && !ovf_seen_r && !standby && !chip_clr |=> ovf_r)
      else $error("overflow cleared without read");
   chk_watchdog_reset_flag_guard: assert property (watchdog_reset_flag_r && !watchdog_reset_flag_seen_r |=> watchdog_reset_flag_r)
      else $error("reset flag cleared without read");
   chk_wd_clear: assert property (chip_clr |=> !tme_r && count_value_r == 8'h00)
      else $error("watchdog reset did not clear timer");
   chk_cnt_wrap: assert property (wrap |=> count_value_r == 8'h00)
      else $error("counter did not wrap to zero");
   chk_pin_drive: assert property (external_reset_output_oe |-> !external_reset_output_o)
      else $error("external reset not driven low");
   chk_ext_start: assert property (wd_fire && reset_output_enable_r |=> external_reset_output_oe)
      else $error("external reset did not start");
   chk_rsvd_rst: assert property (rd_go && avs_address == `WIT_IDX_RST_RD |-> avs_readdata[5:0] == 6'h3f)
      else $error("reset register reserved bits not one");

   cov_interval: cover property (wrap && !mode_r);
   cov_watchdog: cover property (wd_fire && reset_output_enable_r);
   cov_ovf_clear: cover property ($fell(ovf_r) && !chip_clr);
   cov_watchdog_reset_flag_clear: cover property ($fell(watchdog_reset_flag_r));
   cov_standby: cover property (standby && tme_r);

endmodule : wit_top

// ===== test/wit_ext_dev.sv
// External device model watching the open-drain reset pin
module wit_ext_dev (
   input  wire logic ref_clk,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output int        width,
   output int        pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   int   run;
   logic pin;
   // ===================================================================
   // Pull-up holds the released pin high
   assign pin = pin_oe ? pin_o : 1'b1;
   // Low pulse width in states
   always @(posedge ref_clk) begin
      if (pin === 1'b0) begin
         run <= run + 1;
      end else if (run != 0) begin
         width  <= run;
         pulses <= pulses + 1;
         run    <= 0;
      end
   end
endmodule : wit_ext_dev

// ===== test/tb_top.sv
// Self-checking bench of the supervisory timer
`include "wit_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk;
   logic        arst_n;
   logic        avs_read;
   logic        avs_write;
   logic        standby;
   logic [19:0] avs_address;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic        chip_reset_n;
   logic        pin_o;
   logic        pin_oe;
   logic [31:0] rng;
   logic [31:0] q;
   logic [7:0]  v;
   int          n_fail;
   int          n_tests;
   int          rst_lo;
   int          width;
   int          pulses;
   int          divs [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wit_top wit_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .standby(standby),
      .interval_interrupt(irq), .chip_reset_n(chip_reset_n), .external_reset_output_o(pin_o),
      .external_reset_output_oe(pin_oe));
   wit_ext_dev wit_ext_dev_i (.ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .width(width), .pulses(pulses));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (chip_reset_n === 1'b0) begin
         rst_lo <= rst_lo + 1;
      end
   end
   // ===================================================================
   // Helpers
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   function automatic logic [31:0] inr(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
      return {31'h0, (x >= lo && x <= hi)};
   endfunction : inr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up();
      $display("counts tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   task automatic bus(input logic [19:0] a, input logic wr, input logic [15:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address    <= a;
      avs_read       <= !wr;
      avs_write      <= wr;
      avs_writedata  <= {16'h0, d};
      avs_byteenable <= be;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wc(input logic [15:0] d);
      bus(`WIT_IDX_CTL_WR, 1'b1, d, 4'hf);
   endtask : wc
   task automatic wr_rst(input logic [15:0] d);
      bus(`WIT_IDX_RST_WR, 1'b1, d, 4'hf);
   endtask : wr_rst
   task automatic rd(input logic [19:0] a);
      bus(a, 1'b0, 16'h0, 4'hf);
   endtask : rd
   task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
      int n;
      n = 0;
      while ((sel ? chip_reset_n : irq) !== lvl && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= lim) begin
         n_fail++;
         $display("wait hang t=%0t", $time);
      end
   endtask : wait_lvl
   task automatic wd_run(input logic oe_en, input int exp_p);
      int rst_base;
      wr_rst({8'h5a, 1'b0, oe_en, 6'h0});
      standby <= 1'b0;
      wc(16'ha560);
      wc(16'h5afe);
      rst_base = rst_lo;
      wait_lvl(1'b1, 1'b0, 100);
      wait_lvl(1'b1, 1'b1, 1000);
      check(rst_lo - rst_base, 518);
      repeat (2) @(posedge ref_clk);
      check(pulses, exp_p);
      check(width, 132);
      rd(`WIT_IDX_RST_RD);
      check(q, {24'h0, 1'b1, oe_en, 6'h3f});
      rd(`WIT_IDX_CTL_RD);
      check(q, 32'h18);
   endtask : wd_run
   // ===================================================================
   // Watchdog of the run
   initial begin
      #600_000;
      n_fail++;
      $display("timeout t=%0t", $time);
      wrap_up();
   end
   // ===================================================================
   // Main sequence
   initial begin
      rng = 32'he595d140;
      n_fail = 0;
      n_tests = 0;
      arst_n = 1'b0;
      standby = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 20'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(`WIT_IDX_CTL_RD);
      check(q, 32'h18);
      rd(`WIT_IDX_CNT_RD);
      check(q, 32'h0);
      rd(`WIT_IDX_RST_RD);
      check(q, 32'h3f);
      rd(`WIT_IDX_RST_WR);
      check(q, 32'h0);
      v = 8'(xs());
      wc({8'ha5, 3'b100, v[4:0]});
      rd(`WIT_IDX_CTL_RD);
      check(q, {29'h3, v[2:0]});
      wr_rst(16'h5abf);
      rd(`WIT_IDX_RST_RD);
      check(q, 32'h3f);
      wr_rst(16'h5a40);
      rd(`WIT_IDX_RST_RD);
      check(q, 32'h7f);
      wr_rst(16'h5a00);
      wc(16'h5a55);
      rd(`WIT_IDX_CNT_RD);
      check(q, 32'h0);
      $display("test registers done");
      for (int c = 0; c < 8; c++) begin
         wc({8'ha5, 5'h0, c[2:0]});
         wc({8'ha5, 5'h4, c[2:0]});
         repeat (4 * divs[c]) @(posedge ref_clk);
         rd(`WIT_IDX_CNT_RD);
         check(inr(q, 3, 6), 32'h1);
      end
      $display("test count rates done");
      wc(16'ha527);
      v = 8'(xs()) & 8'h7f;
      wc({8'h5a, v});
      bus(`WIT_IDX_CTL_WR, 1'b1, 16'h5aff, 4'h1);
      wc(16'h3cff);
      bus(`WIT_IDX_CNT_RD, 1'b1, 16'h5aff, 4'hf);
      rd(`WIT_IDX_CNT_RD);
      check(inr(q, {24'h0, v}, {24'h0, v} + 1), 32'h1);
      $display("test passwords done");
      wc(16'ha520);
      wc(16'h5afe);
      wait_lvl(1'b0, 1'b1, 100);
      check(chip_reset_n, 1'b1);
      wc(16'ha520);
      rd(`WIT_IDX_CTL_RD);
      check(q, 32'hb8);
      wc(16'ha520);
      rd(`WIT_IDX_CTL_RD);
      check(q, 32'h38);
      check(irq, 1'b0);
      $display("test interval done");
      v = 8'(xs());
      wc({8'ha5, 5'h4, v[2:0]});
      standby <= 1'b1;
      repeat (3) @(posedge ref_clk);
      standby <= 1'b0;
      rd(`WIT_IDX_CTL_RD);
      check(q, {29'h3, v[2:0]});
      rd(`WIT_IDX_CNT_RD);
      check(q, 32'h0);
      $display("test standby done");
      wd_run(1'b1, 1);
      wd_run(1'b0, 1);
      wr_rst(16'h5a00);
      wr_rst(16'ha500);
      rd(`WIT_IDX_RST_RD);
      check(q, 32'hbf);
      wr_rst(16'ha500);
      rd(`WIT_IDX_RST_RD);
      check(q, 32'h3f);
      wd_run(1'b0, 1);
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(`WIT_IDX_RST_RD);
      check(q, 32'h3f);
      $display("test watchdog done");
      wrap_up();
   end
endmodule : tb_top
